/* common/cih_pkg.sv */
// Constants and types shared by the interrupt handler files
package cih_pkg;
    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] CIH_OFF_IV   = 8'h00;
    localparam logic [7:0] CIH_OFF_IMR  = 8'h04;
    localparam logic [7:0] CIH_OFF_IIR  = 8'h08;
    localparam logic [7:0] CIH_OFF_M5ID = 8'h0C;
    localparam logic [7:0] CIH_OFF_CTRL = 8'h10;
    localparam logic [7:0] CIH_OFF_STAT = 8'h14;
    localparam logic [7:0] CIH_OFF_MASK = 8'h18;
    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int CIH_CTRL_GE_BIT  = 0;
    localparam int CIH_CTRL_INS_BIT = 1;
    localparam int CIH_EV_ENTRY     = 0;
    localparam int CIH_EV_RETURN    = 1;
    localparam int CIH_EV_DEFER     = 2;
    localparam int CIH_EV_W         = 3;
    localparam int CIH_M5_SPI_BIT   = 0;
    localparam int CIH_M5_FC_BIT    = 1;
    localparam int CIH_M5_MOD       = 5;
    localparam int CIH_EXT_MOD      = 1;
    localparam logic [15:0] CIH_IV_RST   = 16'h0000;
    localparam logic [15:0] CIH_CTRL_RST = 16'h0000;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CIH_FILT_CYCLES = 3;
    // ---------------------------------------------------------------
    // Handler sequence states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        CIH_ST_IDLE  = 2'b00,
        CIH_ST_STALL = 2'b01,
        CIH_ST_HOLD  = 2'b10,
        CIH_ST_SERVE = 2'b11
    } cih_state_t;
endpackage

/* logic/cih_glitch_filter.sv */
// Synchroniser and sampling glitch filter for one asynchronous request
`timescale 1ns/1ps
module cih_glitch_filter
    import cih_pkg::*;
#(
    parameter int LEN = CIH_FILT_CYCLES
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Request
    input  wire logic async_in,
    input  wire logic stop_mode,
    output logic      filt_out
);
    initial begin
        if (LEN < 2) $error("cih_glitch_filter: LEN must be at least 2");
    end

    logic           meta_ff;
    logic           sync_ff;
    logic [LEN-1:0] hist_ff;
    logic           filt_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    // Output changes only after LEN equal samples, so shorter pulses vanish
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_ff <= '0;
            filt_ff <= 1'b0;
        end else begin
            hist_ff <= {hist_ff[LEN-2:0], sync_ff};
            if (&hist_ff)
                filt_ff <= 1'b1;
            else if (~|hist_ff)
                filt_ff <= 1'b0;
        end
    end

    // In stop mode the clock-based filter is bypassed
    assign filt_out = stop_mode ? sync_ff : filt_ff;
endmodule // cih_glitch_filter

/* logic/cih_src_merge.sv */
// Combines flag and enable pairs of one function into one request bit
`timescale 1ns/1ps
module cih_src_merge #(
    parameter int N = 4
) (
    // Function flags and their enables
    input  wire logic [N-1:0] flags,
    input  wire logic [N-1:0] enables,
    // Combined request
    output logic              req
);
    initial begin
        if (N < 1) $error("cih_src_merge: N must be at least 1");
    end

    assign req = |(flags & enables);
endmodule // cih_src_merge

/* logic/cih_handler.sv */
// Interrupt handler: request merge, call and return sequences, APB registers
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module cih_handler
    import cih_pkg::*;
#(
    parameter int NUM_MOD = 6,
    parameter int SRC_W   = 8,
    parameter int EXT_W   = 7,
    parameter int SPI_W   = 4,
    parameter int FC_W    = 32
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Synchronous peripheral sources
    input  wire logic [NUM_MOD*SRC_W-1:0] sync_flags,
    input  wire logic [NUM_MOD*SRC_W-1:0] sync_enables,
    // Asynchronous external pins, belonging to the external module
    input  wire logic [EXT_W-1:0]   ext_irq_pin,
    input  wire logic [EXT_W-1:0]   ext_irq_en,
    input  wire logic               stop_mode,
    // Module 5 functions
    input  wire logic [SPI_W-1:0]   spi_master_flags,
    input  wire logic [SPI_W-1:0]   spi_master_en,
    input  wire logic [FC_W-1:0]    fast_comparator_flags,
    input  wire logic [FC_W-1:0]    fast_comparator_en,
    // CPU execution status
    input  wire logic               cpu_prefix_write,
    input  wire logic [15:0]        cpu_prefix_data,
    input  wire logic               return_from_interrupt,
    input  wire logic [15:0]        cpu_next_ip,
    input  wire logic [15:0]        stack_top,
    // CPU takeover
    output logic                    irq_ack,
    output logic                    fetch_cancel,
    output logic                    stack_push,
    output logic [15:0]             stack_push_data,
    output logic                    stack_pop,
    output logic                    ip_load,
    output logic [15:0]             ip_load_value,
    output logic                    in_service_flag,
    output logic [15:0]             prefix_register,
    output logic                    prefix_valid,
    // Interrupt to system
    output logic                    irq
);
    initial begin
        if (NUM_MOD <= CIH_M5_MOD) $error("cih_handler: NUM_MOD must exceed 5");
        if (NUM_MOD > 16) $error("cih_handler: NUM_MOD must not exceed 16");
    end

    // ---------------------------------------------------------------
    // Source merging
    // ---------------------------------------------------------------
    logic [NUM_MOD-1:0] sync_req;
    logic [EXT_W-1:0]   ext_filt;
    logic               ext_req;
    logic               m5_spi;
    logic               m5_fc;
    logic [NUM_MOD-1:0] module_req;
    logic [15:0]        module5_irq_source_id;

    // Internal flags reach the handler without any sampling stage
    genvar gi;
    generate
        for (gi = 0; gi < NUM_MOD; gi++) begin : g_mod
            cih_src_merge #(.N(SRC_W)) u_merge (
                .flags   (sync_flags[gi*SRC_W +: SRC_W]),
                .enables (sync_enables[gi*SRC_W +: SRC_W]),
                .req     (sync_req[gi])
            );
        end
        for (gi = 0; gi < EXT_W; gi++) begin : g_ext
            cih_glitch_filter #(.LEN(CIH_FILT_CYCLES)) u_filt (
                .pclk      (pclk),
                .presetn   (presetn),
                .async_in  (ext_irq_pin[gi]),
                .stop_mode (stop_mode),
                .filt_out  (ext_filt[gi])
            );
        end
    endgenerate

    cih_src_merge #(.N(EXT_W)) u_ext_merge (
        .flags   (ext_filt),
        .enables (ext_irq_en),
        .req     (ext_req)
    );
    cih_src_merge #(.N(SPI_W)) u_spi_merge (
        .flags   (spi_master_flags),
        .enables (spi_master_en),
        .req     (m5_spi)
    );
    cih_src_merge #(.N(FC_W)) u_fc_merge (
        .flags   (fast_comparator_flags),
        .enables (fast_comparator_en),
        .req     (m5_fc)
    );

    always_comb begin
        module5_irq_source_id                 = 16'h0000;
        module5_irq_source_id[CIH_M5_SPI_BIT] = m5_spi;
        module5_irq_source_id[CIH_M5_FC_BIT]  = m5_fc;
    end

    // One request line per module, whatever its mix of sources
    always_comb begin
        module_req              = sync_req;
        module_req[CIH_EXT_MOD] = sync_req[CIH_EXT_MOD] | ext_req;
        module_req[CIH_M5_MOD]  = sync_req[CIH_M5_MOD] | m5_spi | m5_fc;
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [15:0]          iv_ff;
    logic [NUM_MOD-1:0]   imr_ff;
    logic                 global_en_ff;
    logic                 ins_ff;
    logic [CIH_EV_W-1:0]  stat_ff;
    logic [CIH_EV_W-1:0]  mask_ff;
    logic [31:0]          rdata_ff;
    logic                 ret_load_ff;
    logic                 win_ff;
    logic [15:0]          pfx_ff;
    logic [15:0]          push_data_ff;
    logic [15:0]          ip_value_ff;
    cih_state_t           state_ff;
    cih_state_t           nxt_state;

    logic                 wr_en;
    logic                 rd_en;
    logic                 setup_rd;
    logic                 addr_ok;
    logic                 req_ok;
    logic [CIH_EV_W-1:0]  ev;

    assign wr_en    = psel & penable & pwrite;
    assign rd_en    = psel & penable & ~pwrite;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign addr_ok  = (paddr == CIH_OFF_IV)   || (paddr == CIH_OFF_IMR)
                   || (paddr == CIH_OFF_IIR)  || (paddr == CIH_OFF_M5ID)
                   || (paddr == CIH_OFF_CTRL) || (paddr == CIH_OFF_STAT)
                   || (paddr == CIH_OFF_MASK);

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata  = rdata_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iv_ff        <= CIH_IV_RST;
            imr_ff       <= '0;
            global_en_ff <= CIH_CTRL_RST[CIH_CTRL_GE_BIT];
            mask_ff      <= '0;
        end else if (wr_en) begin
            if (paddr == CIH_OFF_IV)
                iv_ff <= pwdata[15:0];
            if (paddr == CIH_OFF_IMR)
                imr_ff <= pwdata[NUM_MOD-1:0];
            if (paddr == CIH_OFF_CTRL)
                global_en_ff <= pwdata[CIH_CTRL_GE_BIT];
            if (paddr == CIH_OFF_MASK)
                mask_ff <= pwdata[CIH_EV_W-1:0];
        end
    end

    // Read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (setup_rd) begin
            rdata_ff <= 32'h0000_0000;
            unique case (paddr)
                CIH_OFF_IV:   rdata_ff[15:0]         <= iv_ff;
                CIH_OFF_IMR:  rdata_ff[NUM_MOD-1:0]  <= imr_ff;
                CIH_OFF_IIR:  rdata_ff[NUM_MOD-1:0]  <= module_req;
                CIH_OFF_M5ID: rdata_ff[15:0]         <= module5_irq_source_id;
                CIH_OFF_CTRL: rdata_ff[1:0]          <= {ins_ff, global_en_ff};
                CIH_OFF_STAT: rdata_ff[CIH_EV_W-1:0] <= stat_ff | ev;
                CIH_OFF_MASK: rdata_ff[CIH_EV_W-1:0] <= mask_ff;
                default:      rdata_ff               <= 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Exception window and prefix
    // ---------------------------------------------------------------
    // The prefix lives one cycle only, so the consumer must follow at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_ff <= 1'b0;
            pfx_ff <= 16'h0000;
        end else begin
            win_ff <= cpu_prefix_write;
            pfx_ff <= cpu_prefix_write ? cpu_prefix_data : 16'h0000;
        end
    end

    assign prefix_register = pfx_ff;
    assign prefix_valid    = win_ff;

    // ---------------------------------------------------------------
    // Call sequence
    // ---------------------------------------------------------------
    // No priority encoder: any unmasked module request is enough
    assign req_ok = global_en_ff & ~ins_ff & |(module_req & imr_ff);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            CIH_ST_IDLE: begin
                // Window cycle and return cycle both refuse acknowledgement
                if (req_ok && !win_ff && !return_from_interrupt)
                    nxt_state = CIH_ST_STALL;
            end
            CIH_ST_STALL: begin
                // Current instruction completes here; it may use the stack
                if (cpu_prefix_write || return_from_interrupt)
                    nxt_state = CIH_ST_HOLD;
                else
                    nxt_state = CIH_ST_SERVE;
            end
            CIH_ST_HOLD: nxt_state = CIH_ST_SERVE;
            CIH_ST_SERVE: nxt_state = CIH_ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            state_ff <= CIH_ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    assign irq_ack      = (state_ff == CIH_ST_IDLE) && (nxt_state == CIH_ST_STALL);
    assign fetch_cancel = (state_ff == CIH_ST_SERVE);
    assign stack_push   = (state_ff == CIH_ST_SERVE);
    assign stack_pop    = return_from_interrupt;
    assign ip_load      = (state_ff == CIH_ST_SERVE) | ret_load_ff;
    assign stack_push_data = push_data_ff;
    assign ip_load_value   = ip_value_ff;

    // Return address and target captured the cycle before the takeover
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            push_data_ff <= 16'h0000;
            ip_value_ff  <= 16'h0000;
            ret_load_ff  <= 1'b0;
        end else begin
            ret_load_ff <= return_from_interrupt;
            if (nxt_state == CIH_ST_SERVE) begin
                push_data_ff <= cpu_next_ip;
                ip_value_ff  <= iv_ff;
            end else if (return_from_interrupt) begin
                ip_value_ff <= stack_top;
            end
        end
    end

    // Hardware set wins over a return or a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ins_ff <= 1'b0;
        else if (state_ff == CIH_ST_SERVE)
            ins_ff <= 1'b1;
        else if (return_from_interrupt)
            ins_ff <= 1'b0;
        else if (wr_en && paddr == CIH_OFF_CTRL && !pwdata[CIH_CTRL_INS_BIT])
            ins_ff <= 1'b0;
    end

    assign in_service_flag = ins_ff;

    // ---------------------------------------------------------------
    // Event status and interrupt output
    // ---------------------------------------------------------------
    always_comb begin
        ev                = '0;
        ev[CIH_EV_ENTRY]  = (state_ff == CIH_ST_SERVE);
        ev[CIH_EV_RETURN] = return_from_interrupt;
        ev[CIH_EV_DEFER]  = (state_ff == CIH_ST_IDLE) && req_ok && win_ff;
    end

    // A read clears the status, but an event in that cycle survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            stat_ff <= '0;
        else if (rd_en && paddr == CIH_OFF_STAT)
            stat_ff <= ev;
        else
            stat_ff <= stat_ff | ev;
    end

    assign irq = |(stat_ff & mask_ff);
endmodule // cih_handler

/* tb/cih_handler_monitor.sv */
// Concurrent checks on the interrupt handler ports
`timescale 1ns/1ps
module cih_handler_monitor (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // CPU status
    input wire logic        return_from_interrupt,
    input wire logic        cpu_prefix_write,
    input wire logic [15:0] cpu_prefix_data,
    input wire logic [15:0] cpu_next_ip,
    input wire logic [15:0] stack_top,
    // CPU takeover
    input wire logic        irq_ack,
    input wire logic        fetch_cancel,
    input wire logic        stack_push,
    input wire logic [15:0] stack_push_data,
    input wire logic        stack_pop,
    input wire logic        ip_load,
    input wire logic [15:0] ip_load_value,
    input wire logic        in_service_flag,
    input wire logic [15:0] prefix_register,
    input wire logic        prefix_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ack_to_serve: assert property (irq_ack |=> !fetch_cancel ##[1:2] fetch_cancel)
        else $error("service not two or three cycles after ack");
    a_serve_seq: assert property (fetch_cancel |-> stack_push && ip_load ##1 in_service_flag)
        else $error("service sequence incomplete");
    a_push_addr: assert property (fetch_cancel |-> stack_push_data == $past(cpu_next_ip))
        else $error("pushed address wrong");
    a_ret_seq: assert property (return_from_interrupt && !fetch_cancel |-> stack_pop ##1
        (ip_load && !in_service_flag && ip_load_value == $past(stack_top)))
        else $error("return sequence wrong");
    a_ret_no_ack: assert property (return_from_interrupt |-> !irq_ack)
        else $error("return interrupted");
    a_window_quiet: assert property (prefix_valid |-> !irq_ack)
        else $error("ack inside window");
    a_pfx_hold: assert property (cpu_prefix_write |=> prefix_valid && prefix_register == $past(cpu_prefix_data))
        else $error("prefix not held");
    a_pfx_drop: assert property (!cpu_prefix_write |=> !prefix_valid)
        else $error("prefix held too long");
    a_ins_blocks: assert property (in_service_flag |-> !irq_ack)
        else $error("ack while in service");

    c_plain: cover property (irq_ack ##2 fetch_cancel);
    c_held: cover property (irq_ack ##3 fetch_cancel);
    c_ret_ack: cover property (return_from_interrupt ##1 irq_ack);
endmodule // cih_handler_monitor

/* tb/cih_cpu_model.sv */
// Behavioural CPU core with a small return stack
`timescale 1ns/1ps
module cih_cpu_model (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Takeover from handler
    input wire logic        fetch_cancel,
    input wire logic        stack_push,
    input wire logic [15:0] stack_push_data,
    input wire logic        stack_pop,
    input wire logic        ip_load,
    input wire logic [15:0] ip_load_value,
    // Execution status
    output logic [15:0]     cpu_next_ip,
    output logic [15:0]     stack_top
);
    logic [15:0] ip_ff;
    logic [15:0] stk_ff [8];
    logic [2:0]  sp_ff;

    assign cpu_next_ip = ip_ff + 16'h0001;
    assign stack_top   = stk_ff[sp_ff - 3'h1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ip_ff <= 16'h0100;
        else if (ip_load)
            ip_ff <= ip_load_value;
        else if (!fetch_cancel)
            ip_ff <= cpu_next_ip;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sp_ff <= 3'h0;
        else if (stack_push)
            sp_ff <= sp_ff + 3'h1;
        else if (stack_pop)
            sp_ff <= sp_ff - 3'h1;
    end

    // Contents are unreset, as in a real stack RAM
    always_ff @(posedge pclk) begin
        if (stack_push)
            stk_ff[sp_ff] <= stack_push_data;
    end
endmodule // cih_cpu_model

/* tb/test_cpu_interrupt_handler.sv */
// Self-checking testbench for the interrupt handler
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module test_cpu_interrupt_handler
    import cih_pkg::*;
();
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [47:0] sync_flags, sync_enables;
    logic [6:0]  ext_irq_pin, ext_irq_en;
    logic [3:0]  spi_master_flags, spi_master_en;
    logic [31:0] fast_comparator_flags, fast_comparator_en;
    logic        stop_mode, cpu_prefix_write, return_from_interrupt, irq;
    logic [15:0] cpu_prefix_data, cpu_next_ip, stack_top, ra;
    logic        irq_ack, fetch_cancel, stack_push, stack_pop, ip_load;
    logic        in_service_flag, prefix_valid;
    logic [15:0] stack_push_data, ip_load_value, prefix_register;
    int          n_mismatch, total_checks, n;

    cih_handler i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sync_flags, .sync_enables, .ext_irq_pin, .ext_irq_en, .stop_mode, .spi_master_flags,
        .spi_master_en, .fast_comparator_flags, .fast_comparator_en, .cpu_prefix_write, .cpu_prefix_data,
        .return_from_interrupt, .cpu_next_ip, .stack_top, .irq_ack, .fetch_cancel, .stack_push,
        .stack_push_data, .stack_pop, .ip_load, .ip_load_value, .in_service_flag, .prefix_register,
        .prefix_valid, .irq);
    cih_cpu_model i_cpu (.pclk, .presetn, .fetch_cancel, .stack_push, .stack_push_data, .stack_pop,
        .ip_load, .ip_load_value, .cpu_next_ip, .stack_top);

    // ---------------------------------------------------------------
    // Bus and wait helpers
    // ---------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        `CHK(pready, 1'b1)
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Leaves the caller at the falling edge of the ack cycle, or after lim cycles
    task automatic wait_ack(input int lim);
        n = 0;
        @(negedge pclk);
        while (irq_ack !== 1'b1 && n < lim) begin
            @(negedge pclk);
            n++;
        end
    endtask

    task automatic results;
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_regs;
        apb(0, CIH_OFF_IV, 32'h0000_0000);
        `CHK(q, 32'h0000_0000)
        apb(0, 8'h40, 32'h0000_0000);
        `CHK({err, q}, 33'h1_0000_0000)
    endtask

    task automatic t_call;
        apb(1, CIH_OFF_IV, 32'h0000_1234);
        apb(1, CIH_OFF_IMR, 32'h0000_0008);
        apb(1, CIH_OFF_MASK, 32'h0000_0001);
        apb(1, CIH_OFF_CTRL, 32'h0000_0001);
        sync_flags[24] <= 1'b1;
        sync_enables[24] <= 1'b1;
        wait_ack(3);
        `CHK(n, 0)
        @(negedge pclk);
        ra = cpu_next_ip;
        @(negedge pclk);
        `CHK({fetch_cancel, stack_push, ip_load}, 3'b111)
        `CHK(ip_load_value, 16'h1234)
        `CHK(stack_push_data, ra)
        @(negedge pclk);
        `CHK({in_service_flag, irq}, 2'b11)
        @(posedge pclk);
        apb(0, CIH_OFF_STAT, 32'h0000_0000);
        `CHK(q, 32'h0000_0001)
        @(negedge pclk);
        `CHK(irq, 1'b0)
        @(posedge pclk);
        apb(0, CIH_OFF_IIR, 32'h0000_0000);
        `CHK(q[5:0], 6'h08)
    endtask

    task automatic t_ret;
        return_from_interrupt <= 1'b1;
        @(negedge pclk);
        `CHK({stack_pop, irq_ack}, 2'b10)
        @(posedge pclk);
        return_from_interrupt <= 1'b0;
        @(negedge pclk);
        `CHK({ip_load, in_service_flag, irq_ack}, 3'b101)
        `CHK(ip_load_value, ra)
        repeat (3) @(posedge pclk);
        apb(1, CIH_OFF_CTRL, 32'h0000_0001);
        // The ack falls in the closing idle cycle of the write, so look for the service
        repeat (2) @(negedge pclk);
        `CHK(fetch_cancel, 1'b1)
        @(posedge pclk);
        sync_flags[24] <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(1, CIH_OFF_CTRL, 32'h0000_0001);
    endtask

    task automatic t_mask;
        apb(1, CIH_OFF_IMR, 32'h0000_0000);
        sync_flags[24] <= 1'b1;
        wait_ack(8);
        `CHK(irq_ack, 1'b0)
        @(posedge pclk);
        apb(0, CIH_OFF_IIR, 32'h0000_0000);
        `CHK(q[5:0], 6'h08)
        apb(1, CIH_OFF_CTRL, 32'h0000_0000);
        apb(1, CIH_OFF_IMR, 32'h0000_0008);
        wait_ack(8);
        `CHK(irq_ack, 1'b0)
        @(posedge pclk);
        sync_flags[24] <= 1'b0;
        apb(1, CIH_OFF_CTRL, 32'h0000_0001);
    endtask

    task automatic t_window;
        apb(1, CIH_OFF_MASK, 32'h0000_0000);
        apb(0, CIH_OFF_STAT, 32'h0000_0000);
        cpu_prefix_write <= 1'b1;
        cpu_prefix_data <= 16'hA5C3;
        @(posedge pclk);
        cpu_prefix_write <= 1'b0;
        sync_flags[24] <= 1'b1;
        @(negedge pclk);
        `CHK(prefix_register, 16'hA5C3)
        `CHK({prefix_valid, irq_ack}, 2'b10)
        @(negedge pclk);
        `CHK({prefix_valid, irq_ack}, 2'b01)
        @(posedge pclk);
        cpu_prefix_write <= 1'b1;
        @(posedge pclk);
        cpu_prefix_write <= 1'b0;
        @(negedge pclk);
        `CHK(fetch_cancel, 1'b0)
        @(negedge pclk);
        `CHK(fetch_cancel, 1'b1)
        @(posedge pclk);
        sync_flags[24] <= 1'b0;
        repeat (2) @(posedge pclk);
        apb(0, CIH_OFF_STAT, 32'h0000_0000);
        `CHK({irq, q[2:0]}, 4'b0101)
        apb(1, CIH_OFF_CTRL, 32'h0000_0001);
    endtask

    task automatic t_ext;
        apb(1, CIH_OFF_IMR, 32'h0000_0002);
        ext_irq_en <= 7'h01;
        ext_irq_pin <= 7'h01;
        repeat (2) @(posedge pclk);
        ext_irq_pin <= 7'h00;
        wait_ack(12);
        `CHK(irq_ack, 1'b0)
        @(posedge pclk);
        ext_irq_pin <= 7'h01;
        wait_ack(12);
        `CHK(n >= 4 && n <= 7, 1'b1)
        @(posedge pclk);
        ext_irq_pin <= 7'h00;
        repeat (8) @(posedge pclk);
        apb(1, CIH_OFF_CTRL, 32'h0000_0001);
        // Stop mode skips the filter, so only the two sync stages delay the request
        stop_mode <= 1'b1;
        ext_irq_pin <= 7'h01;
        wait_ack(12);
        `CHK(n >= 1 && n <= 3, 1'b1)
        @(posedge pclk);
        ext_irq_pin <= 7'h00;
        stop_mode <= 1'b0;
    endtask

    task automatic t_m5;
        spi_master_flags <= 4'h8;
        fast_comparator_flags <= 32'h8000_0000;
        apb(0, CIH_OFF_M5ID, 32'h0000_0000);
        `CHK(q, 32'h0000_0000)
        spi_master_en <= 4'h8;
        apb(0, CIH_OFF_M5ID, 32'h0000_0000);
        `CHK(q, 32'h0000_0001)
        fast_comparator_en <= 32'h8000_0000;
        apb(0, CIH_OFF_M5ID, 32'h0000_0000);
        `CHK(q, 32'h0000_0003)
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, sync_flags, sync_enables, ext_irq_pin, ext_irq_en} = '0;
        {spi_master_flags, spi_master_en, fast_comparator_flags, fast_comparator_en, stop_mode} = '0;
        {cpu_prefix_write, cpu_prefix_data, return_from_interrupt, n_mismatch, total_checks} = '0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_call();
        t_ret();
        t_mask();
        t_window();
        t_ext();
        t_m5();
        results();
    end

    initial begin
        repeat (3000) @(posedge pclk);
        n_mismatch++;
        results();
    end
endmodule // test_cpu_interrupt_handler

bind cih_handler cih_handler_monitor i_mon (.pclk, .presetn, .return_from_interrupt, .cpu_prefix_write,
    .cpu_prefix_data, .cpu_next_ip, .stack_top, .irq_ack, .fetch_cancel, .stack_push, .stack_push_data,
    .stack_pop, .ip_load, .ip_load_value, .in_service_flag, .prefix_register, .prefix_valid);
